/* verilog/step_attenuator_serial_ctrl.sv */
`timescale 1ns/1ns

module step_attenuator_serial_ctrl
    import atten_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial port pins
    input wire logic sclk,
    input wire logic sdata,
    input wire logic select_low,
    // Standby pin
    input wire logic amp_active_high_pin,
    // Outputs to the RF section
    output logic [5:0] attenuation_word,
    output logic [5:0] atten_half_db,
    output logic amp_enable
);

    // ****************************************************************
    // Decode function
    // ****************************************************************

    // Inverted weights summed in half-dB units, saturating at 29.5 dB.
    // Each cleared bit adds its own binary weight, so the sum is simply
    // the complement of the word; only the saturation band needs a branch.
    function automatic logic [5:0] decode_atten(input logic [5:0] w);
        logic [5:0] inv;
        inv = ~w;
        if (w <= WORD_SAT_LIMIT) begin
            decode_atten = ATTEN_MAX_HALF_DB;
        end else begin
            decode_atten = inv;
        end
    endfunction

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [1:0] sclk_s_r;
    logic [1:0] sdata_s_r;
    logic [1:0] sel_s_r;
    logic [1:0] amp_active_high_pin_s_r;
    logic sclk_d_r;
    logic sel_d_r;

    // Two flip-flops per pin, the first read only by the second.
    // Select resets high so that a pin already high at release cannot
    // be mistaken for a finished frame.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sclk_s_r <= 2'h0;
            sdata_s_r <= 2'h0;
            sel_s_r <= 2'h3;
            amp_active_high_pin_s_r <= 2'h0;
        end else begin
            sclk_s_r <= {sclk_s_r[0], sclk};
            sdata_s_r <= {sdata_s_r[0], sdata};
            sel_s_r <= {sel_s_r[0], select_low};
            amp_active_high_pin_s_r <= {amp_active_high_pin_s_r[0], amp_active_high_pin};
        end
    end

    // Delayed copies for edge detection on the synchronised levels.
    // Reset values match the idle pin levels, so no false edge follows.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            sclk_d_r <= 1'b0;
            sel_d_r <= 1'b1;
        end else begin
            sclk_d_r <= sclk_s_r[1];
            sel_d_r <= sel_s_r[1];
        end
    end

    logic sclk_rise;
    logic sel_rise;
    logic sel_is_low;
    assign sclk_rise = sclk_s_r[1] & ~sclk_d_r;
    assign sel_rise = sel_s_r[1] & ~sel_d_r;
    assign sel_is_low = ~sel_s_r[1];

    // ****************************************************************
    // Shift register
    // ****************************************************************
    logic [5:0] shift_r;
    logic [5:0] shift_nxt;

    // Data travels in lockstep with the clock through equal sync depth.
    // The data bit is thus seen with the level it had at the clock edge;
    // the host must hold it at least one mclk on either side.
    always_comb begin
        shift_nxt = shift_r;
        if (sel_is_low && sclk_rise) begin
            shift_nxt = {shift_r[4:0], sdata_s_r[1]};
        end
    end

    // Shift register update.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            shift_r <= WORD_RESET;
        end else begin
            shift_r <= shift_nxt;
        end
    end

    // ****************************************************************
    // Holding register and outputs
    // ****************************************************************
    logic [5:0] held_word;

    // Latch on select rise, regardless of standby.
    atten_hold_reg u_hold (
        .mclk(mclk),
        .reset_n(reset_n),
        .load(sel_rise),
        .load_word(shift_r),
        .word(held_word)
    );

    assign attenuation_word = held_word;

    // Registered decode of the held word.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            atten_half_db <= ATTEN_MAX_HALF_DB;
        end else begin
            atten_half_db <= decode_atten(held_word);
        end
    end

    // Amplifier enable follows the synchronised standby pin.
    // The serial port never reads this pin, so words still latch in standby.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            amp_enable <= 1'b0;
        end else begin
            amp_enable <= amp_active_high_pin_s_r[1];
        end
    end

    // ****************************************************************
    // Checker helpers
    // ****************************************************************
    // These feed only the properties below and hold no design state.
    logic [3:0] bits_seen_r;
    logic first_bit_r;

    // Counts accepted bits in the current select-low period, saturating.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            bits_seen_r <= 4'h0;
        end else if (sel_rise) begin
            bits_seen_r <= 4'h0;
        end else if (sel_is_low && sclk_rise && bits_seen_r != 4'hf) begin
            bits_seen_r <= bits_seen_r + 4'h1;
        end
    end

    // Keeps the first bit of each frame, which must end up on top.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            first_bit_r <= 1'b0;
        end else if (sel_is_low && sclk_rise && bits_seen_r == 4'h0) begin
            first_bit_r <= sdata_s_r[1];
        end
    end

    // Sums the weight of every cleared bit, in half-dB units, bit by bit
    // rather than by complement, so the decode is checked another way.
    function automatic logic [5:0] weight_sum(input logic [5:0] w);
        logic [5:0] sum;
        sum = 6'h00;
        for (int i = BIT_HALF_DB; i <= BIT_16DB; i++) begin
            if (!w[i]) begin
                sum = sum + 6'(1 << i);
            end
        end
        weight_sum = sum;
    endfunction

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    hold_when_high_a: assert property (
        !sel_is_low |=> shift_r == $past(shift_r))
        else $error("Shift register changed with select high.");

    shift_on_edge_a: assert property (
        sel_is_low && sclk_rise |=>
            shift_r == {$past(shift_r[4:0]), $past(sdata_s_r[1])})
        else $error("Shift register did not shift on clock edge.");

    msb_first_a: assert property (
        sel_is_low && sclk_rise |=> shift_r[0] == $past(sdata_s_r[1]))
        else $error("Newest bit not at least significant position.");

    latch_on_rise_a: assert property (
        sel_rise |=> held_word == $past(shift_r))
        else $error("Holding register missed select rise.");

    held_stable_a: assert property (
        !sel_rise |=> held_word == $past(held_word))
        else $error("Holding register changed without select rise.");

    latch_in_standby_a: assert property (
        sel_rise && !amp_active_high_pin_s_r[1] |=> held_word == $past(shift_r))
        else $error("Word not latched during standby.");

    decode_sat_a: assert property (
        held_word <= WORD_SAT_LIMIT |=> atten_half_db == ATTEN_MAX_HALF_DB)
        else $error("Saturated code did not give 29.5 dB.");

    decode_weight_a: assert property (
        held_word > WORD_SAT_LIMIT |=> atten_half_db == ~$past(held_word))
        else $error("Attenuation decode mismatch.");

    zero_atten_a: assert property (
        held_word == WORD_ZERO_ATTEN |=> atten_half_db == 6'h00)
        else $error("All ones did not give 0 dB.");

    standby_follow_a: assert property (
        amp_active_high_pin_s_r[1] |=> amp_enable)
        else $error("Amplifier not enabled with standby high.");

    standby_off_a: assert property (
        !amp_active_high_pin_s_r[1] |=> !amp_enable)
        else $error("Amplifier enabled during standby.");

    ignore_clock_a: assert property (
        !sel_is_low && sclk_rise |=> shift_r == $past(shift_r))
        else $error("Clock edge with select high changed the shift register.");

    msb_on_top_a: assert property (
        sel_rise && bits_seen_r == 4'h6 |=>
            held_word[BIT_16DB] == $past(first_bit_r))
        else $error("First bit of a frame did not land on top.");

    shift_in_standby_a: assert property (
        sel_is_low && sclk_rise && !amp_active_high_pin_s_r[1] |=>
            shift_r == {$past(shift_r[4:0]), $past(sdata_s_r[1])})
        else $error("Shift register stalled during standby.");

    latch_in_run_a: assert property (
        sel_rise && amp_active_high_pin_s_r[1] |=> held_word == $past(shift_r))
        else $error("Word not latched with amplifier running.");

    decode_sum_a: assert property (
        held_word > WORD_SAT_LIMIT |=>
            atten_half_db == weight_sum($past(held_word)))
        else $error("Weighted sum of cleared bits mismatch.");

    decode_in_standby_a: assert property (
        !amp_active_high_pin_s_r[1] && held_word > WORD_SAT_LIMIT |=>
            atten_half_db == weight_sum($past(held_word)))
        else $error("Decode stalled during standby.");

    wake_applies_a: assert property (
        $rose(amp_enable) && $stable(held_word) |->
            atten_half_db == ((held_word <= WORD_SAT_LIMIT) ?
                ATTEN_MAX_HALF_DB : weight_sum(held_word)))
        else $error("Stored setting not applied on leaving standby.");

    // The reset checks below must run while reset is held, so they
    // replace the default disable condition with one that never fires.
    reset_word_a: assert property (
        disable iff (1'b0) !reset_n |=> held_word == WORD_RESET)
        else $error("Holding register not cleared by reset.");

    reset_atten_a: assert property (
        disable iff (1'b0) !reset_n |=> atten_half_db == ATTEN_MAX_HALF_DB)
        else $error("Attenuation not at maximum after reset.");

    reset_amp_a: assert property (
        disable iff (1'b0) !reset_n |=> !amp_enable)
        else $error("Amplifier enabled during reset.");

    shift_cov: cover property (sel_is_low && sclk_rise);
    latch_cov: cover property (sel_rise);
    sat_cov: cover property (held_word <= WORD_SAT_LIMIT && sel_d_r);
    amp_active_high_pin_latch_cov: cover property (sel_rise && !amp_active_high_pin_s_r[1]);
    long_frame_cov: cover property (sel_rise && bits_seen_r > 4'h6);

endmodule

/* verilog/atten_pkg.sv */
package atten_pkg;

    // ****************************************************************
    // Word format and decode constants
    // ****************************************************************
    localparam int WORD_W = 6;
    localparam logic [5:0] WORD_RESET = 6'h00;
    localparam logic [5:0] WORD_SAT_LIMIT = 6'h04;
    localparam logic [5:0] WORD_ZERO_ATTEN = 6'h3f;
    localparam int BIT_HALF_DB = 0;
    localparam int BIT_16DB = 5;
    // Attenuation is reported in half-dB units; 29.5 dB is 59 steps.
    localparam int ATTEN_W = 6;
    localparam logic [5:0] ATTEN_MAX_HALF_DB = 6'h3b;

    // ****************************************************************
    // Timing constants of the far side, in ns and in mclk cycles
    // ****************************************************************
    localparam int MCLK_PERIOD_NS = 4;
    localparam int SCLK_MIN_PERIOD_NS = 40;
    localparam int SCLK_MIN_PHASE_NS = 20;
    localparam int SEL_MIN_HIGH_NS = 10;
    localparam int SCLK_MIN_PHASE_CYC =
        (SCLK_MIN_PHASE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int SEL_MIN_HIGH_CYC =
        (SEL_MIN_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

/* verilog/atten_hold_reg.sv */
`timescale 1ns/1ns

// Holding register for the attenuation word, registered output.
module atten_hold_reg
    import atten_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Load port
    input wire logic load,
    input wire logic [5:0] load_word,
    // Held word
    output logic [5:0] word
);

    // Load a new word; power-up value selects maximum attenuation.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            word <= WORD_RESET;
        end else if (load) begin
            word <= load_word;
        end
    end

endmodule

/* bench/host_model.sv */
`timescale 1ns/1ns

// ****************************************************************
// Host controller that frames attenuation words onto the serial pins
// ****************************************************************
module host_model
    import atten_pkg::*;
(
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic sclk,
    output logic sdata,
    output logic select_low
);
    // The serial clock rests low outside frames and select rests high.
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        select_low = 1'b1;
    end

    // Sends n bits, top bit first, 40 ns per clock; csel low keeps select high.
    // The low phase is the first edge plus four more, the high phase five.
    task automatic send(input logic [7:0] bits, input int n, input bit csel);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge mclk);
            select_low <= ~csel;
            sdata <= bits[i];
            repeat (SCLK_MIN_PHASE_CYC - 1) @(posedge mclk);
            sclk <= 1'b1;
            repeat (SCLK_MIN_PHASE_CYC) @(posedge mclk);
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        select_low <= 1'b1;
        sdata <= ~sdata;
        repeat (4) @(posedge mclk);
    endtask
endmodule

/* bench/tb.sv */
`timescale 1ns/1ns

// ****************************************************************
// Self-checking bench for the serial attenuation control
// ****************************************************************
module tb;
    import atten_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic amp_active_high_pin = 1'b1;
    logic sclk, sdata, select_low, amp_enable;
    logic [5:0] attenuation_word, atten_half_db, last_w, e, w, sent;
    logic [5:0] exp_q[$];
    logic [5:0] codes[13] = '{6'h3f, 6'h3e, 6'h3d, 6'h3b, 6'h37, 6'h2f,
        6'h1f, 6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;

    // Free-running system clock.
    initial begin
        forever #2 mclk = ~mclk;
    end

    step_attenuator_serial_ctrl DUT (.mclk(mclk), .reset_n(reset_n),
        .sclk(sclk), .sdata(sdata), .select_low(select_low),
        .amp_active_high_pin(amp_active_high_pin),
        .attenuation_word(attenuation_word),
        .atten_half_db(atten_half_db), .amp_enable(amp_enable));
    host_model host (.mclk(mclk), .sclk(sclk), .sdata(sdata),
        .select_low(select_low));

    // Expected decode: low codes saturate, others are the inverted word.
    function automatic logic [5:0] dec(input logic [5:0] x);
        return (x <= WORD_SAT_LIMIT) ? ATTEN_MAX_HALF_DB : ~x;
    endfunction

    task automatic chk(input logic [5:0] got, input logic [5:0] want);
        cmp_count++;
        if (got !== want) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, want);
        end
    endtask

    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Notes the word expected to latch, then sends the frame.
    task automatic xfer(input logic [7:0] bits, input int n,
        input logic [5:0] x);
        exp_q.push_back(x);
        host.send(bits, n, 1'b1);
        sent = x;
    endtask

    // Waits a bounded time for every noted word to appear.
    task automatic drain;
        for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge mclk);
        chk(6'(exp_q.size()), 6'h00);
    endtask

    // Each new held word is compared with the oldest note, decode next cycle.
    // Outputs are read on the falling edge, well after they have settled.
    initial begin
        last_w = WORD_RESET;
        forever begin
            @(negedge mclk);
            if (reset_n === 1'b1 && attenuation_word !== last_w) begin
                last_w = attenuation_word;
                e = (exp_q.size() > 0) ? exp_q.pop_front() : ~last_w;
                @(negedge mclk);
                chk(attenuation_word, e);
                chk(atten_half_db, dec(e));
            end
        end
    end

    // Cuts a hung run short.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            $display("unexpected at %0t: timeout", $time);
            give_verdict();
        end
    end

    // Main sequence of tests.
    initial begin
        void'($urandom(32'he2bb5e4d));
        sent = WORD_RESET;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        #1;
        chk(attenuation_word, WORD_RESET);
        chk(atten_half_db, ATTEN_MAX_HALF_DB);
        chk({5'h00, amp_enable}, 6'h00);
        repeat (8) @(posedge mclk);
        chk({5'h00, amp_enable}, 6'h01);
        $display("test reset done");
        foreach (codes[i]) xfer({2'b00, codes[i]}, 6, codes[i]);
        drain();
        $display("test decode done");
        for (int i = 0; i < 8; i++) begin
            w = 6'($urandom);
            if (w == sent) w = ~w;
            xfer({2'b00, w}, 6, w);
        end
        if (sent !== 6'h2a) xfer(8'h2a, 6, 6'h2a);
        host.send(8'h05, 3, 1'b0);
        xfer(8'h05, 3, 6'h15);
        xfer(8'hc7, 8, 6'h07);
        drain();
        $display("test framing done");
        @(posedge mclk);
        amp_active_high_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        chk({5'h00, amp_enable}, 6'h00);
        xfer(8'h3c, 6, 6'h3c);
        drain();
        @(posedge mclk);
        amp_active_high_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({5'h00, amp_enable}, 6'h01);
        chk(atten_half_db, 6'h03);
        $display("test standby done");
        give_verdict();
    end
endmodule
